// ---- src/sps_pkg.sv ----
// shared constants, register layouts and types of the serial port
package sps_pkg;

  // ****************************************************************
  // register port
  // ****************************************************************
  localparam int unsigned ADDR_W   = 2;
  localparam logic [1:0]  REG_CTRL = 2'h0;
  localparam logic [1:0]  REG_STAT = 2'h1;
  localparam logic [1:0]  REG_DATA = 2'h2;
  localparam logic [1:0]  REG_DIR  = 2'h3;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  typedef struct packed {
    logic       ie;
    logic       en;
    logic       lsbf;
    logic       master_select_bit;
    logic       cpol;
    logic       cpha;
    logic [1:0] rate;
  } sps_ctrl_t;

  typedef struct packed {
    logic       transfer_complete_flag;
    logic       wcol;
    logic       ovr;
    logic [2:0] rsvd;
    logic       busy;
    logic       selected;
  } sps_stat_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       ss_val;
    logic       ss;
    logic       sck;
    logic       miso;
    logic       mosi;
  } sps_dir_t;

  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss;
  } sps_pins_t;

  localparam sps_ctrl_t CTRL_RST = 8'h00;
  localparam sps_dir_t  DIR_RST  = 8'h00;
  localparam sps_pins_t PINS_IDLE = 4'h0;

  // ****************************************************************
  // timing and sizes
  // ****************************************************************
  localparam int unsigned SCK_HALF_BASE = 4;
  localparam int unsigned RX_DEPTH      = 8;
  localparam int unsigned DATA_W        = 8;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_EDGE     = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_SHIFT = 3'b100
  } sps_state_t;

endpackage : sps_pkg

// ---- src/sps_fifo.sv ----
// small first-in first-out buffer with a registered output stage
module sps_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready_o = (cnt_ff != FULL_CNT);
  assign push       = in_valid_i && in_ready_o;
  // the output stage reloads whenever it is empty or being drained
  assign pop        = (cnt_ff != '0) && (!out_valid_o || out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_ff[rd_ptr_ff];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule : sps_fifo

// ---- src/sps_port.sv ----
// serial peripheral port: master or slave, register port, receive stream
// What this block does
// - one transmit byte; writes during shifting refused
// - last byte readable; unread byte lost on next
// - enabled port overrides pin directions per mode
// - master with select output: plain output only
// - select low as master: drop to slave
// - fall-back sets completion flag, maybe interrupt
// - stays slave until software sets master again
// - slave always treats select as input
// - slave active only while selected; miso per user
module sps_port
  import sps_pkg::*;
#(
  parameter int unsigned HALF_BASE = SCK_HALF_BASE,
  parameter int unsigned DEPTH     = RX_DEPTH
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  // interrupt
  input  wire logic              global_ie_i,
  output logic                   irq_o,
  // serial pins
  input  wire sps_pins_t         pin_i,
  output sps_pins_t              pin_o,
  output sps_pins_t              pin_oe_o,
  // receive stream
  output logic [DATA_W-1:0]      rx_data_o,
  output logic                   rx_valid_o,
  input  wire logic              rx_ready_i
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r,
                               input logic stb);
    return stb && (a == r);
  endfunction : hit

  function automatic logic out_bit(input logic [7:0] s, input logic lsbf);
    return lsbf ? s[0] : s[7];
  endfunction : out_bit

  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b,
                                          input logic lsbf);
    return lsbf ? {b, s[7:1]} : {s[6:0], b};
  endfunction : shift_in

  // ****************************************************************
  // declarations
  // ****************************************************************
  sps_ctrl_t  ctrl_ff;
  sps_dir_t   dir_ff;
  sps_state_t state_ff;
  sps_pins_t  sync1_ff;
  sps_pins_t  sync2_ff;
  logic       sck_prev_ff;
  logic [7:0] shreg_ff;
  logic [7:0] rx_hold_ff;
  logic       out_ff;
  logic       sck_lvl_ff;
  logic [7:0] half_cnt_ff;
  logic [3:0] edge_cnt_ff;
  logic [3:0] bitcnt_ff;
  logic       flag_ff;
  logic       wcol_ff;
  logic       ovr_ff;
  logic       armed_ff;
  logic       unread_ff;
  logic [7:0] half_len;
  logic       wr_ctrl, wr_dir, wr_data, rd_data, rd_stat;
  logic       mst, fallback, slv_sel, busy, data_ok;
  logic       tick, m_lead, m_trail, m_done, s_lead, s_trail;
  logic       lead, trail, sample, drive, done, in_bit;
  logic       fifo_ready;
  logic [7:0] nxt_shreg;
  logic [7:0] rx_byte;
  sps_stat_t  stat;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff    <= PINS_IDLE;
      sync2_ff    <= PINS_IDLE;
      sck_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= pin_i;
      sync2_ff    <= sync1_ff;
      sck_prev_ff <= sync2_ff.sck;
    end
  end

  // ****************************************************************
  // decode and events
  // ****************************************************************
  assign wr_ctrl  = hit(reg_addr_i, REG_CTRL, reg_wr_i);
  assign wr_dir   = hit(reg_addr_i, REG_DIR, reg_wr_i);
  assign wr_data  = hit(reg_addr_i, REG_DATA, reg_wr_i);
  assign rd_data  = hit(reg_addr_i, REG_DATA, reg_rd_i);
  assign rd_stat  = hit(reg_addr_i, REG_STAT, reg_rd_i);

  assign mst      = ctrl_ff.en && ctrl_ff.master_select_bit;
  // select as an output never reaches the mode logic
  assign fallback = mst && !dir_ff.ss && !sync2_ff.ss;
  assign slv_sel  = ctrl_ff.en && !ctrl_ff.master_select_bit
                    && !sync2_ff.ss;
  assign busy     = (state_ff != ST_IDLE) || (bitcnt_ff != '0);
  assign data_ok  = wr_data && !busy;

  assign half_len = 8'(HALF_BASE) << ctrl_ff.rate;
  assign tick     = (state_ff == ST_SHIFT) && (half_cnt_ff == half_len - 8'h01);
  assign m_lead   = tick && !edge_cnt_ff[0];
  assign m_trail  = tick && edge_cnt_ff[0];
  assign m_done   = m_trail && (edge_cnt_ff == LAST_EDGE);
  assign s_lead   = slv_sel && (ctrl_ff.cpol ? (sck_prev_ff && !sync2_ff.sck)
                                             : (!sck_prev_ff && sync2_ff.sck));
  assign s_trail  = slv_sel && (ctrl_ff.cpol ? (!sck_prev_ff && sync2_ff.sck)
                                             : (sck_prev_ff && !sync2_ff.sck));
  assign lead     = mst ? m_lead : s_lead;
  assign trail    = mst ? m_trail : s_trail;
  assign sample   = ctrl_ff.cpha ? trail : lead;
  assign drive    = ctrl_ff.cpha ? lead : trail;
  assign in_bit   = mst ? sync2_ff.miso : sync2_ff.mosi;
  assign nxt_shreg = shift_in(shreg_ff, in_bit, ctrl_ff.lsbf);
  // with sampling on the leading edge the closing edge only drives,
  // so the byte already sits complete in the shift register
  assign rx_byte  = sample ? nxt_shreg : shreg_ff;
  // a byte ends after eight samples
  assign done     = mst ? m_done
                        : (sample && (bitcnt_ff == BYTE_BITS - 4'h1));

  // ****************************************************************
  // control and direction registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= sps_ctrl_t'(reg_wdata_i);
    end else if (fallback) begin
      ctrl_ff.master_select_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_ff <= DIR_RST;
    end else if (wr_dir) begin
      dir_ff <= sps_dir_t'(reg_wdata_i);
    end
  end

  // ****************************************************************
  // master sequencer
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
    end else if (!mst || fallback) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          // a full receive buffer holds the master back
          if (data_ok) begin
            state_ff <= fifo_ready ? ST_SHIFT : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (fifo_ready) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (m_done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_cnt_ff <= '0;
      edge_cnt_ff <= '0;
      sck_lvl_ff  <= 1'b0;
    end else if (state_ff != ST_SHIFT) begin
      half_cnt_ff <= '0;
      edge_cnt_ff <= '0;
      sck_lvl_ff  <= ctrl_ff.cpol;
    end else if (tick) begin
      half_cnt_ff <= '0;
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
      sck_lvl_ff  <= !sck_lvl_ff;
    end else begin
      half_cnt_ff <= half_cnt_ff + 8'h01;
    end
  end

  // ****************************************************************
  // shifter
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg_ff  <= '0;
      out_ff    <= 1'b0;
      bitcnt_ff <= '0;
    end else begin
      if (data_ok) begin
        shreg_ff <= reg_wdata_i;
        out_ff   <= out_bit(reg_wdata_i, ctrl_ff.lsbf);
      end else begin
        if (sample) begin
          shreg_ff <= nxt_shreg;
        end
        if (drive) begin
          out_ff <= out_bit(shreg_ff, ctrl_ff.lsbf);
        end
      end
      // deselect abandons a partial slave byte
      if (done || !(slv_sel || state_ff == ST_SHIFT)) begin
        bitcnt_ff <= '0;
      end else if (sample) begin
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
    end
  end

  // ****************************************************************
  // receive holding register and status
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_hold_ff <= '0;
      unread_ff  <= 1'b0;
    end else begin
      if (done) begin
        rx_hold_ff <= rx_byte;
      end
      unread_ff <= done || (unread_ff && !rd_data);
    end
  end

  // clearing takes a status read while set, then a data access;
  // a new event in the clearing cycle wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_ff  <= 1'b0;
      wcol_ff  <= 1'b0;
      ovr_ff   <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      if (done || fallback) begin
        flag_ff <= 1'b1;
      end else if (armed_ff && (rd_data || wr_data)) begin
        flag_ff <= 1'b0;
      end
      if (wr_data && busy) begin
        wcol_ff <= 1'b1;
      end else if (armed_ff && (rd_data || wr_data)) begin
        wcol_ff <= 1'b0;
      end
      if (done && (unread_ff || !fifo_ready)) begin
        ovr_ff <= 1'b1;
      end else if (armed_ff && (rd_data || wr_data)) begin
        ovr_ff <= 1'b0;
      end
      if (rd_stat) begin
        armed_ff <= flag_ff || wcol_ff || ovr_ff;
      end else if (rd_data || wr_data) begin
        armed_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    stat                        = '0;
    stat.transfer_complete_flag = flag_ff;
    stat.wcol                   = wcol_ff;
    stat.ovr                    = ovr_ff;
    stat.busy                   = busy;
    stat.selected               = slv_sel;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: reg_rdata_o <= ctrl_ff;
        REG_STAT: reg_rdata_o <= stat;
        REG_DATA: reg_rdata_o <= rx_hold_ff;
        REG_DIR:  reg_rdata_o <= dir_ff;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ctrl_ff.ie && flag_ff && global_ie_i;
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o    <= PINS_IDLE;
      pin_oe_o <= PINS_IDLE;
    end else if (!ctrl_ff.en) begin
      pin_oe_o <= {dir_ff.mosi, dir_ff.miso, dir_ff.sck, dir_ff.ss};
      pin_o    <= {1'b0, 1'b0, ctrl_ff.cpol, dir_ff.ss_val};
    end else if (ctrl_ff.master_select_bit) begin
      pin_oe_o <= {dir_ff.mosi, 1'b0, dir_ff.sck, dir_ff.ss};
      pin_o    <= {out_ff, 1'b0, sck_lvl_ff, dir_ff.ss_val};
    end else begin
      // a slave only drives miso while selected and allowed
      pin_oe_o <= {1'b0, dir_ff.miso && !sync2_ff.ss, 1'b0, 1'b0};
      pin_o    <= {1'b0, out_ff, 1'b0, 1'b0};
    end
  end

  // ****************************************************************
  // receive stream buffer
  // ****************************************************************
  sps_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (done),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rx_byte),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wcol_set_a: assert property (
    wr_data && busy |=> wcol_ff && shreg_ff == $past(rx_byte))
    else $error("busy write not refused");
  rx_keep_a: assert property (
    done |=> rx_hold_ff == $past(rx_byte) && unread_ff)
    else $error("completed byte not held");
  rx_lost_a: assert property (
    done && unread_ff |=> ovr_ff)
    else $error("overwrite not reported");
  mst_pins_a: assert property (
    mst |=> !pin_oe_o.miso && pin_oe_o.mosi == $past(dir_ff.mosi))
    else $error("master pin override wrong");
  ss_gpo_a: assert property (
    mst && dir_ff.ss && !wr_ctrl |=> ctrl_ff.master_select_bit
    && pin_o.ss == $past(dir_ff.ss_val))
    else $error("select output disturbed master");
  fall_back_a: assert property (
    fallback && !wr_ctrl |=> !ctrl_ff.master_select_bit
    ##1 !pin_oe_o.mosi && !pin_oe_o.sck)
    else $error("no fall-back to slave");
  fall_flag_a: assert property (
    fallback |=> flag_ff)
    else $error("fall-back flag missing");
  stay_slave_a: assert property (
    !ctrl_ff.master_select_bit && !wr_ctrl |=> !ctrl_ff.master_select_bit)
    else $error("master bit set without write");
  ss_input_a: assert property (
    ctrl_ff.en && !ctrl_ff.master_select_bit |=> !pin_oe_o.ss)
    else $error("slave drives select");
  miso_idle_a: assert property (
    ctrl_ff.en && !ctrl_ff.master_select_bit && sync2_ff.ss |=> !pin_oe_o.miso)
    else $error("unselected slave drives miso");
  byte_len_a: assert property (
    m_done |-> bitcnt_ff == (ctrl_ff.cpha ? BYTE_BITS - 4'h1 : BYTE_BITS))
    else $error("master byte not eight bits");

  mst_xfer_c: cover property (mst && m_done);
  slv_xfer_c: cover property (slv_sel && done);
  fall_back_c: cover property (fallback);
  stall_c: cover property (state_ff == ST_WAIT ##1 state_ff == ST_SHIFT);

endmodule : sps_port

// ---- bench/sps_peer.sv ----
// behavioural far-side party: slave answering on miso, or master with select
module sps_peer
  import sps_pkg::*;
(
  // role: 1 acts as master
  input  wire logic      mst_i,
  // resolved pin levels
  input  wire sps_pins_t line_i,
  // party drive
  output sps_pins_t      drv_o,
  output sps_pins_t      oe_o,
  output logic [7:0]     rx_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] sh_ff;
  logic       ss_ff;
  logic       sck_ff;
  logic       mosi_ff;

  initial begin
    ss_ff   = 1'b1;
    sck_ff  = 1'b0;
    mosi_ff = 1'b0;
    sh_ff   = 8'h00;
    rx_o    = 8'h00;
  end

  assign oe_o  = mst_i ? 4'hb : 4'h4;
  assign drv_o = {mosi_ff, sh_ff[7], sck_ff, ss_ff};

  // as slave: sample on rise, shift on fall
  always @(posedge line_i.sck) if (!mst_i) rx_o <= {rx_o[6:0], line_i.mosi};
  always @(negedge line_i.sck) if (!mst_i) sh_ff <= {sh_ff[6:0], 1'b0};

  task load(input logic [7:0] b);
    sh_ff = b;
  endtask : load

  task sel(input logic l);
    ss_ff = l;
    #400;
  endtask : sel

  // 400 ns link period; miso read late in the high phase since the
  // port's synchroniser delays its answer by about four clocks
  task xbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi_ff = b[i];
      #200 sck_ff = 1'b1;
      #150 rx_o = {rx_o[6:0], line_i.miso};
      #50 sck_ff = 1'b0;
    end
    #200;
  endtask : xbyte
endmodule : sps_peer

// ---- bench/sps_port_tb_top.sv ----
// self-checking bench of the serial port over its register port
module sps_port_tb_top
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata;
  logic              global_ie;
  logic              irq;
  sps_pins_t         line;
  sps_pins_t         pin_o;
  sps_pins_t         pin_oe;
  sps_pins_t         pdrv;
  sps_pins_t         poe;
  logic [7:0]        prx;
  logic              peer_mst;
  logic              flt;
  logic [7:0]        rx_data;
  logic              rx_valid;
  logic              rx_ready;
  int                miscompares;
  int                checks_done;

  // ****************************************************************
  // design, partner and wire resolution
  // ****************************************************************
  sps_port u_sps_port (
    .clk_i(clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .global_ie_i(global_ie), .irq_o(irq),
    .pin_i(line), .pin_o(pin_o), .pin_oe_o(pin_oe), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready));

  sps_peer u_sps_peer (.mst_i(peer_mst), .line_i(line), .drv_o(pdrv),
    .oe_o(poe), .rx_o(prx));

  // undriven lines wander, select has a pull-up
  function automatic logic res(logic d, logic de, logic p, logic pe, logic i);
    return de ? d : (pe ? p : i);
  endfunction : res

  assign line.mosi = res(pin_o.mosi, pin_oe.mosi, pdrv.mosi, poe.mosi, flt);
  assign line.miso = res(pin_o.miso, pin_oe.miso, pdrv.miso, poe.miso, flt);
  assign line.sck  = res(pin_o.sck, pin_oe.sck, pdrv.sck, poe.sck, flt);
  assign line.ss   = res(pin_o.ss, pin_oe.ss, pdrv.ss, poe.ss, 1'b1);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) flt <= ~flt;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task rchk(input string nm, input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask : rchk

  // poll status until the shifter is free, bounded
  task idle();
    logic [7:0] s;
    int n;
    s = 8'h02;
    n = 0;
    while (s[1] !== 1'b0 && n < 200) begin
      rd(REG_STAT, s);
      n++;
    end
    chk("busy", 8'h00, {7'h0, s[1]});
  endtask : idle

  task pop(input logic [7:0] e);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk("rx_valid", 8'h01, {7'h0, rx_valid});
    chk("rx_data", e, rx_data);
    @(posedge clk);
    rx_ready <= rx_valid;
    @(posedge clk);
    rx_ready <= 1'b0;
    #1;
  endtask : pop

  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [7:0] v;
    rst = 1'b1; reg_addr = '0; reg_wdata = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; global_ie = 1'b1; rx_ready = 1'b0; peer_mst = 1'b0;
    flt = 1'b0; miscompares = 0; checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl", REG_CTRL, 8'h00);
    rchk("stat", REG_STAT, 8'h00);
    rchk("dir", REG_DIR, 8'h00);
    chk("pin_oe", 8'h00, {4'h0, pin_oe});
    $display("test reset done");
    // master byte, second write refused while shifting
    wr(REG_DIR, 8'h1d);
    wr(REG_CTRL, 8'h50);
    u_sps_peer.load(8'h3c);
    cyc(2);
    chk("pin_oe", 8'h0b, {4'h0, pin_oe});
    wr(REG_DATA, 8'ha5);
    wr(REG_DATA, 8'h11);
    idle();
    chk("peer_rx", 8'ha5, prx);
    rchk("stat", REG_STAT, 8'hc0);
    rchk("data", REG_DATA, 8'h3c);
    rchk("stat", REG_STAT, 8'h00);
    pop(8'h3c);
    $display("test master done");
    // select as output is a plain pin
    wr(REG_DIR, 8'h0d);
    cyc(10);
    chk("ss_line", 8'h00, {7'h0, line.ss});
    rchk("ctrl", REG_CTRL, 8'h50);
    rchk("stat", REG_STAT, 8'h00);
    $display("test ss output done");
    // select input pulled low while master; raise the pin before
    // releasing it so the synchroniser never shows a stale low
    wr(REG_DIR, 8'h1d);
    cyc(4);
    wr(REG_DIR, 8'h05);
    wr(REG_CTRL, 8'hd0);
    @(posedge clk);
    peer_mst <= 1'b1;
    u_sps_peer.sel(1'b0);
    cyc(6);
    chk("irq", 8'h01, {7'h0, irq});
    chk("pin_oe", 8'h00, {4'h0, pin_oe});
    rchk("ctrl", REG_CTRL, 8'hc0);
    rchk("stat", REG_STAT, 8'h81);
    @(posedge clk);
    global_ie <= ~irq;
    cyc(3);
    chk("irq", 8'h00, {7'h0, irq});
    rd(REG_DATA, v);
    u_sps_peer.sel(1'b1);
    cyc(10);
    rchk("ctrl", REG_CTRL, 8'hc0);
    $display("test fall back done");
    // slave, lsb first: two bytes without a read between
    wr(REG_CTRL, 8'h60);
    wr(REG_DIR, 8'h0a);
    cyc(4);
    chk("pin_oe", 8'h00, {4'h0, pin_oe});
    wr(REG_DATA, 8'h83);
    u_sps_peer.sel(1'b0);
    chk("pin_oe", 8'h04, {4'h0, pin_oe});
    u_sps_peer.xbyte(8'h5a);
    chk("peer_rx", 8'hc1, prx);
    u_sps_peer.xbyte(8'hc1);
    u_sps_peer.sel(1'b1);
    chk("pin_oe", 8'h00, {4'h0, pin_oe});
    rchk("stat", REG_STAT, 8'ha0);
    rchk("data", REG_DATA, 8'h83);
    pop(8'h5a);
    pop(8'h83);
    $display("test slave done");
    // fill the stream buffer until the master stalls, then drain
    wr(REG_DIR, 8'h1d);
    @(posedge clk);
    peer_mst <= 1'b0;
    wr(REG_CTRL, 8'h51);
    rchk("ctrl", REG_CTRL, 8'h51);
    for (int i = 0; i < 9; i++) begin
      u_sps_peer.load(8'h40 + 8'(i));
      wr(REG_DATA, 8'(i));
      idle();
    end
    u_sps_peer.load(8'h49);
    wr(REG_DATA, 8'h09);
    cyc(100);
    rchk("stat", REG_STAT, 8'h02);
    for (int i = 0; i < 10; i++) pop(8'h40 + 8'(i));
    chk("peer_rx", 8'h09, prx);
    $display("test buffer done");
    print_verdict();
  end

  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule : sps_port_tb_top
